// >>> rtl/atw_age_tick.sv
// divider that turns the system clock into a one-cycle aging period pulse
`timescale 1ns/100ps
module atw_age_tick #(
	parameter longint unsigned PERIOD_CYCLES = atw_pkg::AGE_PERIOD_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	typedef struct packed {
		logic [63:0] count;
		logic tick;
	} atw_tick_state_t;

	atw_tick_state_t st_r;
	atw_tick_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.count >= PERIOD_CYCLES - 64'd1)
		begin
			st_nxt.count = 64'd0;
			st_nxt.tick = 1'b1;
		end
		else
			st_nxt.count = st_r.count + 64'd1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tick = st_r.tick;
endmodule

// >>> rtl/atw_pkg.sv
// package: register map, entry layout, reset values and aging timing for the table staging block
package atw_pkg;
	localparam logic [12:0] IDX_MAC_LOW = 13'h1801;
	localparam logic [12:0] IDX_MAC_HIGH = 13'h1802;
	localparam logic [14:0] ADDR_MAC_LOW = {IDX_MAC_LOW, 2'b00};
	localparam logic [14:0] ADDR_MAC_HIGH = {IDX_MAC_HIGH, 2'b00};
	localparam int APB_AW = 16;
	localparam int BIT_VALID = 24;
	localparam int BIT_AGE = 23;
	localparam int BIT_STATIC = 22;
	localparam int BIT_FILTER = 21;
	localparam int BIT_PRIO_LO = 19;
	localparam int BIT_PORT_LO = 16;
	localparam int BIT_PORT_MULTI = 18;
	localparam logic [31:0] HIGH_WMASK = 32'h01ffffff;
	localparam logic [31:0] MAC_LOW_RESET = 32'h00000000;
	localparam logic [31:0] MAC_HIGH_RESET = 32'h00000000;
	localparam int TABLE_DEPTH = 16;
	localparam logic [2:0] PORT_CODE_RSVD = 3'h3;
	localparam longint unsigned CLK_HZ = 64'd250000000;
	localparam longint unsigned AGE_PERIOD_MIN = 64'd5;
	localparam longint unsigned AGE_PERIOD_CYCLES = AGE_PERIOD_MIN * 64'd60 * CLK_HZ;

	typedef struct packed {
		logic valid;
		logic age;
		logic fixed;
		logic filter;
		logic [1:0] prio;
		logic [2:0] port;
		logic [47:0] mac;
	} atw_entry_t;

	typedef struct packed {
		logic hit;
		logic filter;
		logic override;
		logic prio_valid;
		logic [1:0] prio;
		logic [2:0] ports;
	} atw_dst_result_t;
endpackage

// >>> rtl/atw_table_write.sv
// staging registers on apb, commit of the staged entry and a small aging lookup table
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
module atw_table_write #(
	parameter int DEPTH = atw_pkg::TABLE_DEPTH,
	parameter longint unsigned AGE_PERIOD_CYCLES = atw_pkg::AGE_PERIOD_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [atw_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic make_entry,
	output logic make_done,
	output atw_pkg::atw_entry_t committed_entry,
	input wire logic dest_match_priority_first,
	input wire logic learn_req,
	input wire logic [47:0] learn_mac,
	input wire logic [2:0] learn_port,
	input wire logic dst_req,
	input wire logic [47:0] dst_mac,
	output atw_pkg::atw_dst_result_t dst_result
);
	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef atw_pkg::atw_entry_t [DEPTH-1:0] atw_table_t;

	typedef struct packed {
		logic hit;
		logic [IW-1:0] idx;
	} atw_find_t;

	typedef struct packed {
		logic [31:0] mac_low;
		logic [31:0] mac_high;
		logic ack;
		logic [31:0] rdata;
		logic err;
		logic make_seen;
		logic done;
		atw_pkg::atw_entry_t committed;
		logic [IW-1:0] victim;
		atw_table_t table_q;
		atw_pkg::atw_dst_result_t dst;
	} atw_state_t;

	atw_state_t st_r;
	atw_state_t st_nxt;
	logic age_tick;

	atw_age_tick #(
		.PERIOD_CYCLES(AGE_PERIOD_CYCLES)
	) u_age_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick(age_tick)
	);

	function automatic atw_find_t find_mac(input atw_table_t t, input logic [47:0] mac);
		atw_find_t f;
		f = '0;
		for (int i = DEPTH - 1; i >= 0; i--)
		begin
			if (t[i].valid && t[i].mac == mac)
			begin
				f.hit = 1'b1;
				f.idx = IW'(i);
			end
		end
		return f;
	endfunction

	function automatic atw_find_t find_free(input atw_table_t t);
		atw_find_t f;
		f = '0;
		for (int i = DEPTH - 1; i >= 0; i--)
		begin
			if (!t[i].valid)
			begin
				f.hit = 1'b1;
				f.idx = IW'(i);
			end
		end
		return f;
	endfunction

	// reserved code 011 forwards nowhere rather than guessing a port
	function automatic logic [2:0] port_mask(input logic [2:0] code);
		logic [2:0] m;
		m = 3'h0;
		if (code[2])
			unique case (code[1:0])
				2'b00: m = 3'h3;
				2'b01: m = 3'h5;
				2'b10: m = 3'h6;
				2'b11: m = 3'h7;
			endcase
		else if (code != atw_pkg::PORT_CODE_RSVD)
			m = 3'h1 << code[1:0];
		return m;
	endfunction

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		return r;
	endfunction

	// bit 0 selects the low word and bit 1 the high word; anything else is refused
	function automatic logic [1:0] reg_hit(input logic [atw_pkg::APB_AW-1:0] a);
		logic [1:0] h;
		h = 2'b00;
		if (a[atw_pkg::APB_AW-1:15] == '0)
		begin
			h[0] = a[14:0] == atw_pkg::ADDR_MAC_LOW;
			h[1] = a[14:0] == atw_pkg::ADDR_MAC_HIGH;
		end
		return h;
	endfunction

	// one place builds the staged word, so commit and any later reader agree on the layout
	function automatic atw_pkg::atw_entry_t stage_entry(input logic [31:0] lo,
		input logic [31:0] hi);
		atw_pkg::atw_entry_t e;
		e = '0;
		e.valid = hi[atw_pkg::BIT_VALID];
		e.age = hi[atw_pkg::BIT_AGE];
		e.fixed = hi[atw_pkg::BIT_STATIC];
		e.filter = hi[atw_pkg::BIT_FILTER];
		e.prio = hi[atw_pkg::BIT_PRIO_LO +: 2];
		e.port = hi[atw_pkg::BIT_PORT_LO +: 3];
		e.mac = {hi[15:0], lo};
		return e;
	endfunction

	// a miss returns all zero so the forwarding side sees no stale attributes
	function automatic atw_pkg::atw_dst_result_t dst_decode(input atw_pkg::atw_entry_t e,
		input logic hit, input logic prio_en);
		atw_pkg::atw_dst_result_t r;
		r = '0;
		if (hit)
		begin
			r.hit = 1'b1;
			r.filter = e.filter;
			r.override = e.fixed && e.age;
			r.prio_valid = e.fixed && prio_en;
			r.prio = e.prio;
			r.ports = port_mask(e.port);
		end
		return r;
	endfunction

	always_comb
	begin
		atw_pkg::atw_entry_t staged;
		atw_find_t fm;
		atw_find_t ff;
		atw_find_t fl;
		atw_find_t fd;
		logic [IW-1:0] slot;
		logic [1:0] hit;
		logic mapped;
		staged = '0;
		fm = '0;
		ff = '0;
		fl = '0;
		fd = '0;
		slot = '0;
		st_nxt = st_r;
		hit = reg_hit(paddr);
		mapped = |hit;

		// one wait state lets read data come from a flop
		st_nxt.ack = 1'b0;
		if (psel && penable && !st_r.ack)
		begin
			st_nxt.ack = 1'b1;
			st_nxt.err = !mapped;
			st_nxt.rdata = 32'h00000000;
			if (!pwrite && hit[0])
				st_nxt.rdata = st_r.mac_low;
			else if (!pwrite && hit[1])
				st_nxt.rdata = st_r.mac_high & atw_pkg::HIGH_WMASK;
		end
		if (psel && penable && st_r.ack && pwrite && mapped)
		begin
			if (hit[0])
				st_nxt.mac_low = apply_strb(st_r.mac_low, pwdata, pstrb);
			else
				st_nxt.mac_high = apply_strb(st_r.mac_high, pwdata, pstrb)
					& atw_pkg::HIGH_WMASK;
		end

		staged = stage_entry(st_r.mac_low, st_r.mac_high);
		// aging, learning and commit may land in one cycle; the later code wins a slot

		// aging: a set age bit buys one more period, so removal lands in 5 to 10 minutes
		if (age_tick)
			for (int i = 0; i < DEPTH; i++)
				if (st_r.table_q[i].valid && !st_r.table_q[i].fixed)
				begin
					if (st_r.table_q[i].age)
						st_nxt.table_q[i].age = 1'b0;
					else
						st_nxt.table_q[i].valid = 1'b0;
				end

		// learning refreshes dynamic entries and never touches static ones
		// a full table drops the new address, so learning never evicts a manual entry
		if (learn_req)
		begin
			fl = find_mac(st_r.table_q, learn_mac);
			ff = find_free(st_r.table_q);
			if (fl.hit && !st_r.table_q[fl.idx].fixed)
			begin
				st_nxt.table_q[fl.idx].age = 1'b1;
				st_nxt.table_q[fl.idx].port = learn_port;
				st_nxt.table_q[fl.idx].valid = 1'b1;
			end
			else if (!fl.hit && ff.hit)
			begin
				st_nxt.table_q[ff.idx] = '0;
				st_nxt.table_q[ff.idx].valid = 1'b1;
				st_nxt.table_q[ff.idx].age = 1'b1;
				st_nxt.table_q[ff.idx].port = learn_port;
				st_nxt.table_q[ff.idx].mac = learn_mac;
			end
		end

		// commit on the rising edge of make_entry only; it wins over aging and learning
		st_nxt.make_seen = make_entry;
		if (!make_entry)
			st_nxt.done = 1'b0;
		if (make_entry && !st_r.make_seen)
		begin
			fm = find_mac(st_r.table_q, staged.mac);
			ff = find_free(st_r.table_q);
			// a full table overwrites in round robin order, learned and manual entries alike
			slot = fm.hit ? fm.idx : (ff.hit ? ff.idx : st_r.victim);
			if (staged.valid)
			begin
				st_nxt.table_q[slot] = staged;
				if (!fm.hit && !ff.hit)
					st_nxt.victim = IW'(st_r.victim + 1'b1);
			end
			else if (fm.hit)
				st_nxt.table_q[fm.idx] = '0;
			st_nxt.committed = staged;
			st_nxt.done = 1'b1;
		end

		// destination lookup, one cycle of latency
		fd = find_mac(st_r.table_q, dst_mac);
		if (dst_req)
			st_nxt.dst = dst_decode(st_r.table_q[fd.idx], fd.hit, dest_match_priority_first);
	end

	// the table sits in flops; at this depth a memory macro would cost more than it saves
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.mac_low <= atw_pkg::MAC_LOW_RESET;
			st_r.mac_high <= atw_pkg::MAC_HIGH_RESET;
		end
		else
			st_r <= st_nxt;
	end

	assign prdata = st_r.rdata;
	assign pready = st_r.ack;
	assign pslverr = st_r.ack & st_r.err;
	assign make_done = st_r.done;
	assign committed_entry = st_r.committed;
	assign dst_result = st_r.dst;
endmodule

// >>> tb/atw_table_write_sva.sv
// assertion checker for the table staging block ports
`timescale 1ns/100ps
module atw_table_write_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [atw_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic make_entry,
	input wire logic make_done,
	input wire atw_pkg::atw_entry_t committed_entry,
	input wire logic dst_req,
	input wire atw_pkg::atw_dst_result_t dst_result
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic lo_hit;
	logic hi_hit;
	assign lo_hit = paddr == 16'(atw_pkg::ADDR_MAC_LOW);
	assign hi_hit = paddr == 16'(atw_pkg::ADDR_MAC_HIGH);
	wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	unmapped_err_a: assert property (pready && !lo_hit && !hi_hit |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (pready && (lo_hit || hi_hit) |-> !pslverr)
		else $error("mapped access refused");
	rsvd_zero_a: assert property (pready && hi_hit |-> prdata[31:25] == 7'h0)
		else $error("reserved bits read nonzero");
	done_rise_a: assert property ($rose(make_entry) |=> make_done)
		else $error("make_done missing after command");
	done_fall_a: assert property (!make_entry |=> !make_done)
		else $error("make_done without command");
	entry_hold_a: assert property (!$rose(make_entry) |=> $stable(committed_entry))
		else $error("entry changed without command");
	lookup_hold_a: assert property (!dst_req |=> $stable(dst_result))
		else $error("lookup result changed without request");
	cover property (pready && pslverr);
	cover property ($rose(make_done));
	cover property (dst_result.hit && dst_result.filter);
endmodule

bind atw_table_write atw_table_write_chk i_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
	.pready, .pslverr, .make_entry, .make_done, .committed_entry, .dst_req, .dst_result);

// >>> tb/atw_table_write_test.sv
// self-checking bench for the table staging block
`timescale 1ns/100ps
module atw_table_write_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, make_entry = 0, make_done, dmpf = 0, learn_req = 0, dst_req = 0, er;
	logic [47:0] learn_mac = 48'h0, dst_mac = 48'h0;
	logic [2:0] learn_port = 3'h0;
	atw_pkg::atw_entry_t committed_entry;
	atw_pkg::atw_dst_result_t dst_result;
	int fail_count = 0, cmp_count = 0;
	localparam logic [15:0] LO = 16'(atw_pkg::ADDR_MAC_LOW), HI = 16'(atw_pkg::ADDR_MAC_HIGH);
	atw_table_write #(.AGE_PERIOD_CYCLES(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .make_entry, .make_done,
		.committed_entry, .dest_match_priority_first(dmpf), .learn_req, .learn_mac,
		.learn_port, .dst_req, .dst_mac, .dst_result);
	initial forever #2 pclk = ~pclk;
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task make(input logic [31:0] lo, input logic [31:0] hi);
		apb(1, LO, lo, 4'hf);
		apb(1, HI, hi, 4'hf);
		make_entry <= 1;
		do @(posedge pclk); while (make_done !== 1'b1);
		chk("entry", {hi[24:0], lo}, committed_entry);
		make_entry <= 0;
		repeat (2) @(posedge pclk);
	endtask
	// prio is only meaningful with prio_valid, so t_codes masks it off otherwise; t_age compares it with 9'h1ff only in its first two lookups
	task look(input logic [47:0] m, input logic [8:0] e, input logic [8:0] k);
		@(posedge pclk);
		{dst_req, dst_mac} <= {1'b1, m};
		@(posedge pclk);
		dst_req <= 0;
		#1 chk("lookup", e & k, dst_result & k);
	endtask
	task t_regs;
		apb(0, LO, 0, 4'hf);
		chk("low reset", 0, rd);
		apb(0, HI, 0, 4'hf);
		chk("high reset", 0, rd);
		apb(1, LO, 32'hffffffff, 4'hf);
		apb(1, LO, 32'h0, 4'h1);
		apb(0, LO, 0, 4'hf);
		chk("low strobe", 32'hffffff00, rd);
		apb(1, HI, 32'hffffffff, 4'hf);
		apb(0, HI, 0, 4'hf);
		chk("high rsvd", 32'h01ffffff, rd);
		apb(1, 16'h6000, 32'h5, 4'hf);
		chk("unmapped", 33'h100000000, {er, rd});
		look(48'hffffffffff00, 0, 9'h100);
	endtask
	task t_codes;
		logic [2:0] pm[8];
		pm = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
		for (int i = 0; i < 8; i++)
		begin
			make(32'h44330000 | i, 32'h01400000 | (i[0] << 21) | (i[1] << 23) | (i[1:0] << 19)
				| (i << 16) | 32'h0a0a);
			dmpf <= i[2];
			look({16'h0a0a, 32'h44330000 | i}, {1'b1, i[0], i[1], i[2], i[1:0], pm[i]},
				i[2] ? 9'h1ff : 9'h1e7);
		end
		make(32'h44330000, 32'h0a0a);
		look(48'h0a0a44330000, 0, 9'h100);
	endtask
	task t_age;
		make(32'h5, 32'h0180beef);
		look(48'hbeef00000005, 9'h101, 9'h1ff);
		@(posedge pclk);
		{learn_req, learn_mac, learn_port} <= {1'b1, 48'h0a0a44330001, 3'h2};
		@(posedge pclk);
		learn_mac <= 48'h00000000abcd;
		@(posedge pclk);
		learn_req <= 0;
		look(48'h00000000abcd, 9'h104, 9'h1ff);
		repeat (50) @(posedge pclk);
		look(48'hbeef00000005, 0, 9'h100);
		look(48'h00000000abcd, 0, 9'h100);
		look(48'h0a0a44330001, 9'h102, 9'h107);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_codes;
		t_age;
		finish_test;
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		finish_test;
	end
endmodule
